// >>> hdl/scievt_map.svh
// Constants for the event status and enable logic
`ifndef SCIEVT_MAP_SVH
`define SCIEVT_MAP_SVH
`define SCIEVT_GPE_MAX 256
`define SCIEVT_GPE0_BITS 8
`define SCIEVT_GPE1_BITS 8
`define SCIEVT_FIX_BITS 8
`define SCIEVT_FIX_TMR 0
`define SCIEVT_FIX_BM 1
`define SCIEVT_FIX_GBL 2
`define SCIEVT_FIX_PWRBTN 3
`define SCIEVT_FIX_SLPBTN 4
`define SCIEVT_FIX_ALARM 5
`define SCIEVT_FIX_WAKE 6
`define SCIEVT_FIX_RSVD 7
`define SCIEVT_TMR_BITS 24
`define SCIEVT_RESET_EN 8'h00
`endif

// >>> hdl/scievt_pkg.sv
// Types for the event status and enable logic
`include "scievt_map.svh"
package scievt_pkg;
    typedef logic [`SCIEVT_FIX_BITS-1:0] scievt_fix_type;
    typedef logic [`SCIEVT_GPE0_BITS-1:0] scievt_gpe0_type;
    typedef logic [`SCIEVT_GPE1_BITS-1:0] scievt_gpe1_type;
    // Software access to one status/enable block
    typedef struct packed {
        logic [`SCIEVT_FIX_BITS-1:0] sts_clr;
        logic en_we;
        logic [`SCIEVT_FIX_BITS-1:0] en_wdata;
    } scievt_sw_type;
    typedef enum logic {SCIEVT_EDGE, SCIEVT_LEVEL} scievt_kind_type;
endpackage

// >>> hdl/scievt_top.sv
// Event status/enable blocks driving a shared level interrupt
// Contract
// - enabled fixed status raises interrupt
// - each general status has matching enable
// - at most 256 general status bits
// - enabled general status raises interrupt
// - interrupt level-sensitive and shareable
// - two separate general event blocks
// - timer carry sets timer status
// - power button sets fixed status
// - buttons only notify in working state; no power state is tracked here, buttons always set status
// - optional sleep button status bit
// - alarm status bit, optional
// - wake completion sets wake status
// - bus master cycle sets status
// - lock release sets status
// - status latches, cleared writing one
// - general enables read and write
// - each input level or edge
`timescale 1ns/100ps
`include "scievt_map.svh"
module scievt_top
    import scievt_pkg::*;
#(
    parameter scievt_gpe0_type GPE0_LEVEL = 8'h0f,
    parameter scievt_gpe1_type GPE1_LEVEL = 8'h0f,
    parameter logic HAS_SLEEP_BUTTON = 1'b1,
    parameter logic HAS_ALARM_STATUS = 1'b1,
    parameter logic HAS_BUS_MASTER_STATUS = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Event sources
    input wire logic timer_tick_i,
    input wire logic power_button_i,
    input wire logic sleep_button_i,
    input wire logic alarm_i,
    input wire logic wake_done_i,
    input wire logic bus_master_cycle_i,
    input wire logic lock_release_i,
    input wire scievt_gpe0_type gpe0_src_i,
    input wire scievt_gpe1_type gpe1_src_i,
    // Software access
    input wire scievt_sw_type fixed_sw_i,
    input wire scievt_sw_type gpe0_sw_i,
    input wire scievt_sw_type gpe1_sw_i,
    output scievt_fix_type fixed_event_status_o,
    output scievt_fix_type fixed_event_enable_o,
    output scievt_gpe0_type first_block_status_o,
    output scievt_gpe0_type first_block_enable_o,
    output scievt_gpe1_type second_block_status_o,
    output scievt_gpe1_type second_block_enable_o,
    output logic [`SCIEVT_TMR_BITS-1:0] timer_count_value_o,
    output logic system_control_irq_o
);

    // ----------------------------------------
    // Power-management timer
    // ----------------------------------------
    logic [`SCIEVT_TMR_BITS-1:0] tmr_ff;
    logic [`SCIEVT_TMR_BITS:0] nxt_tmr;
    wire timer_carry = nxt_tmr[`SCIEVT_TMR_BITS] & timer_tick_i;
    assign nxt_tmr = {1'b0, tmr_ff} + {{`SCIEVT_TMR_BITS{1'b0}}, 1'b1};

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tmr_ff <= '0;
        end else if (timer_tick_i) begin
            tmr_ff <= nxt_tmr[`SCIEVT_TMR_BITS-1:0];
        end
    end
    assign timer_count_value_o = tmr_ff;

    // ----------------------------------------
    // Shared decode helpers
    // ----------------------------------------
    // Latch on a rising edge, or on every high cycle where the input is built as a level
    function automatic scievt_fix_type event_set(input scievt_fix_type src, input scievt_fix_type prev,
        input scievt_fix_type level_mask);
        event_set = src & (level_mask | ~prev);
    endfunction

    // A new event wins over a write-one clear that lands in the same cycle
    function automatic scievt_fix_type status_next(input scievt_fix_type sts, input scievt_fix_type clr,
        input scievt_fix_type fire);
        status_next = (sts & ~clr) | fire;
    endfunction

    // Any status bit that is both set and enabled
    function automatic logic pending_any(input scievt_fix_type sts, input scievt_fix_type en);
        pending_any = |(sts & en);
    endfunction

    // ----------------------------------------
    // Edge detection of sources
    // ----------------------------------------
    // Buttons only post status; nothing here touches the power state
    scievt_fix_type fix_prev_ff;
    scievt_gpe0_type gpe0_prev_ff;
    scievt_gpe1_type gpe1_prev_ff;
    scievt_fix_type fix_lvl;
    scievt_fix_type fix_set;
    scievt_gpe0_type gpe0_set;
    scievt_gpe1_type gpe1_set;

    assign fix_lvl[`SCIEVT_FIX_TMR] = timer_carry;
    assign fix_lvl[`SCIEVT_FIX_BM] = bus_master_cycle_i & HAS_BUS_MASTER_STATUS;
    assign fix_lvl[`SCIEVT_FIX_GBL] = lock_release_i;
    assign fix_lvl[`SCIEVT_FIX_PWRBTN] = power_button_i;
    assign fix_lvl[`SCIEVT_FIX_SLPBTN] = sleep_button_i & HAS_SLEEP_BUTTON;
    assign fix_lvl[`SCIEVT_FIX_ALARM] = alarm_i & HAS_ALARM_STATUS;
    assign fix_lvl[`SCIEVT_FIX_WAKE] = wake_done_i;
    assign fix_lvl[`SCIEVT_FIX_RSVD] = 1'b0;

    // Fixed events are edge latched, so a held source posts only once
    localparam scievt_fix_type FIX_LEVEL = 8'h00;
    assign fix_set = event_set(fix_lvl, fix_prev_ff, FIX_LEVEL);
    // Level inputs keep setting while high, so a clear before service re-latches
    assign gpe0_set = event_set(gpe0_src_i, gpe0_prev_ff, GPE0_LEVEL);
    assign gpe1_set = event_set(gpe1_src_i, gpe1_prev_ff, GPE1_LEVEL);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fix_prev_ff <= '0;
        end else begin
            fix_prev_ff <= fix_lvl;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gpe0_prev_ff <= '0;
        end else begin
            gpe0_prev_ff <= gpe0_src_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gpe1_prev_ff <= '0;
        end else begin
            gpe1_prev_ff <= gpe1_src_i;
        end
    end

    // ----------------------------------------
    // Status and enable blocks
    // ----------------------------------------
    scievt_fix_type fix_sts_ff;
    scievt_fix_type fix_en_ff;
    scievt_gpe0_type gpe0_sts_ff;
    scievt_gpe0_type gpe0_en_ff;
    scievt_gpe1_type gpe1_sts_ff;
    scievt_gpe1_type gpe1_en_ff;
    scievt_fix_type nxt_fix_sts;
    scievt_gpe0_type nxt_gpe0_sts;
    scievt_gpe1_type nxt_gpe1_sts;

    // Set wins over a write-one clear in the same cycle
    assign nxt_fix_sts = status_next(fix_sts_ff, fixed_sw_i.sts_clr, fix_set);
    assign nxt_gpe0_sts = status_next(gpe0_sts_ff, gpe0_sw_i.sts_clr, gpe0_set);
    assign nxt_gpe1_sts = status_next(gpe1_sts_ff, gpe1_sw_i.sts_clr, gpe1_set);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fix_sts_ff <= '0;
        end else begin
            fix_sts_ff <= nxt_fix_sts;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gpe0_sts_ff <= '0;
        end else begin
            gpe0_sts_ff <= nxt_gpe0_sts;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gpe1_sts_ff <= '0;
        end else begin
            gpe1_sts_ff <= nxt_gpe1_sts;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fix_en_ff <= `SCIEVT_RESET_EN;
        end else if (fixed_sw_i.en_we) begin
            fix_en_ff <= fixed_sw_i.en_wdata;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gpe0_en_ff <= `SCIEVT_RESET_EN;
        end else if (gpe0_sw_i.en_we) begin
            gpe0_en_ff <= gpe0_sw_i.en_wdata;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gpe1_en_ff <= `SCIEVT_RESET_EN;
        end else if (gpe1_sw_i.en_we) begin
            gpe1_en_ff <= gpe1_sw_i.en_wdata;
        end
    end

    // ----------------------------------------
    // Shared interrupt
    // ----------------------------------------
    // Plain level, no pulse stretching, so other low-rate sources can share the vector
    wire fix_irq = pending_any(fix_sts_ff, fix_en_ff);
    wire gpe_irq = pending_any(gpe0_sts_ff, gpe0_en_ff) | pending_any(gpe1_sts_ff, gpe1_en_ff);
    assign system_control_irq_o = fix_irq | gpe_irq;

    assign fixed_event_status_o = fix_sts_ff;
    assign fixed_event_enable_o = fix_en_ff;
    assign first_block_status_o = gpe0_sts_ff;
    assign first_block_enable_o = gpe0_en_ff;
    assign second_block_status_o = gpe1_sts_ff;
    assign second_block_enable_o = gpe1_en_ff;

endmodule

// >>> tb/scievt_host.sv
// Host interrupt input model on a shared level line
`timescale 1ns/100ps
module scievt_host (
    input wire logic clk_i,
    input wire logic irq_i,
    input wire logic other_irq_i,
    output logic pending_o
);
    // Line is shared, so only the level is meaningful, never an edge
    always_ff @(posedge clk_i) begin
        pending_o <= irq_i | other_irq_i;
    end
endmodule

// >>> tb/scievt_sva.sv
// Checker for the event status and interrupt logic
`timescale 1ns/100ps
module scievt_sva
    import scievt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic power_button_i,
    input wire logic wake_done_i,
    input wire logic lock_release_i,
    input wire scievt_sw_type fixed_sw_i,
    input wire scievt_fix_type fixed_event_status_o,
    input wire scievt_fix_type fixed_event_enable_o,
    input wire scievt_gpe0_type first_block_status_o,
    input wire scievt_gpe0_type first_block_enable_o,
    input wire scievt_gpe1_type second_block_status_o,
    input wire scievt_gpe1_type second_block_enable_o,
    input wire logic system_control_irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic fx = |(fixed_event_status_o & fixed_event_enable_o);
    wire logic gx = |(first_block_status_o & first_block_enable_o) | |(second_block_status_o & second_block_enable_o);
    a_fix_irq: assert property (fx |-> system_control_irq_o) else $error("fixed event without irq");
    a_gen_irq: assert property (gx |-> system_control_irq_o) else $error("general event without irq");
    a_irq_cause: assert property (system_control_irq_o |-> fx || gx) else $error("irq without cause");
    a_button_latch: assert property ($rose(power_button_i) |=> fixed_event_status_o[3]) else $error("button lost");
    a_wake_latch: assert property ($rose(wake_done_i) |=> fixed_event_status_o[6]) else $error("wake lost");
    a_lock_latch: assert property ($rose(lock_release_i) |=> fixed_event_status_o[2]) else $error("lock lost");
    a_status_sticky: assert property (
        fixed_event_status_o[3] && !fixed_sw_i.sts_clr[3] |=> fixed_event_status_o[3])
        else $error("status dropped");
    a_clear_one: assert property (fixed_sw_i.sts_clr[3] && !power_button_i |=> !fixed_event_status_o[3])
        else $error("clear ignored");
    a_reserved_zero: assert property (!fixed_event_status_o[7]) else $error("reserved bit set");
endmodule
bind scievt_top scievt_sva chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .power_button_i(power_button_i),
    .wake_done_i(wake_done_i), .lock_release_i(lock_release_i), .fixed_sw_i(fixed_sw_i),
    .fixed_event_status_o(fixed_event_status_o), .fixed_event_enable_o(fixed_event_enable_o),
    .first_block_status_o(first_block_status_o), .first_block_enable_o(first_block_enable_o),
    .second_block_status_o(second_block_status_o), .second_block_enable_o(second_block_enable_o),
    .system_control_irq_o(system_control_irq_o));

// >>> tb/scievt_top_bench.sv
// Self-checking bench for the event status and interrupt logic
`timescale 1ns/100ps
`define CHK(n, e, s) begin \
    check_count++; \
    if ((s) !== (e)) begin \
        err_total++; \
        $display("CHECK FAILED %s exp %h got %h", n, e, s); \
    end \
end
module scievt_top_bench;
    import scievt_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, oth = 1'b0, irq, pend;
    logic [6:0] fs = '0;
    logic [7:0] g0 = '0, g1 = '0, fst, fen, g0st, g0en, g1st, g1en;
    logic [23:0] tmr;
    scievt_sw_type fsw = '0, g0sw = '0, g1sw = '0;
    int err_total = 0, check_count = 0;
    scievt_top dut (.clk_i(clk), .rst_n_i(rst_n), .timer_tick_i(fs[0]), .power_button_i(fs[3]),
        .sleep_button_i(fs[4]), .alarm_i(fs[5]), .wake_done_i(fs[6]), .bus_master_cycle_i(fs[1]),
        .lock_release_i(fs[2]), .gpe0_src_i(g0), .gpe1_src_i(g1), .fixed_sw_i(fsw), .gpe0_sw_i(g0sw),
        .gpe1_sw_i(g1sw), .fixed_event_status_o(fst), .fixed_event_enable_o(fen), .first_block_status_o(g0st),
        .first_block_enable_o(g0en), .second_block_status_o(g1st), .second_block_enable_o(g1en),
        .timer_count_value_o(tmr), .system_control_irq_o(irq));
    scievt_host host (.clk_i(clk), .irq_i(irq), .other_irq_i(oth), .pending_o(pend));
    initial begin
        forever #10 clk = ~clk;
    end
    // The line is up while any set bit is also enabled
    function automatic logic exp_irq(input logic [7:0] sts, input logic [7:0] en);
        return |(sts & en);
    endfunction
    // One-cycle software access, then idle for a cycle so accesses never collide
    task automatic sw(ref scievt_sw_type s, input logic we, input logic [7:0] d, input logic [7:0] c);
        s = {c, we, d};
        @(negedge clk);
        s = '0;
        @(negedge clk);
    endtask
    task automatic finish_test();
        if (err_total == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        logic [7:0] en;
        int n;
        void'($urandom(32'h3598c596));
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        `CHK("rst_val", 73'h0, {tmr, fst, fen, g0st, g0en, g1st, g1en, irq})
        n = 1 + $urandom % 40;
        fs[0] = 1'b1;
        repeat (n) @(negedge clk);
        fs[0] = 1'b0;
        `CHK("timer", 24'(n), tmr)
        `CHK("tmr_nocarry", 1'b0, fst[0])
        for (int k = 1; k < 7; k++) begin
            en = 8'($urandom) & 8'h7f;
            sw(fsw, 1'b1, en, 8'h00);
            fs[k] = 1'b1;
            @(negedge clk);
            fs[k] = 1'b0;
            @(negedge clk);
            `CHK("fix_sts", 8'h01 << k, fst)
            `CHK("fix_en", en, fen)
            `CHK("fix_irq", exp_irq(8'h01 << k, en), irq)
            `CHK("host", exp_irq(8'h01 << k, en), pend)
            sw(fsw, 1'b1, 8'h00, 8'h00);
            `CHK("fix_off", 1'b0, irq)
            sw(fsw, 1'b0, 8'h00, 8'h01 << k);
            `CHK("fix_clr", 8'h00, fst)
        end
        // A fresh edge in the cycle of a clear keeps the bit set
        fs[3] = 1'b1;
        @(negedge clk);
        fs[3] = 1'b0;
        @(negedge clk);
        fsw.sts_clr = 8'h08;
        fs[3] = 1'b1;
        @(negedge clk);
        fsw.sts_clr = 8'h00;
        fs[3] = 1'b0;
        @(negedge clk);
        `CHK("set_wins", 8'h08, fst)
        sw(fsw, 1'b0, 8'h00, 8'h08);
        `CHK("clr_after", 8'h00, fst)
        en = 8'($urandom) | 8'h01;
        sw(g0sw, 1'b1, 8'hff, 8'h00);
        g0 = en;
        @(negedge clk);
        g0 = '0;
        @(negedge clk);
        `CHK("gpe0_sts", en, g0st)
        `CHK("gpe0_irq", 1'b1, irq)
        sw(g0sw, 1'b1, en, 8'hff);
        `CHK("gpe0_clr", 8'h00, g0st)
        `CHK("gpe0_en", en, g0en)
        g1 = 8'h11;
        @(negedge clk);
        sw(g1sw, 1'b1, en, 8'hff);
        `CHK("gpe1_lvl", 8'h01, g1st)
        `CHK("gpe1_irq", en[0], irq)
        `CHK("gpe1_en", en, g1en)
        g1 = '0;
        sw(g1sw, 1'b0, 8'h00, 8'hff);
        `CHK("gpe1_clr", 9'h000, {g1st, irq})
        // Another source on the shared line must not disturb this one
        oth = 1'b1;
        @(negedge clk);
        oth = 1'b0;
        `CHK("shared", 2'b10, {pend, irq})
        // Mid-run reset drops every latched bit and enable
        g0 = en;
        @(negedge clk);
        `CHK("pre_rst", 1'b1, irq)
        g0 = '0;
        rst_n = 1'b0;
        @(negedge clk);
        `CHK("rst_mid", 73'h0, {tmr, fst, fen, g0st, g0en, g1st, g1en, irq})
        rst_n = 1'b1;
        g0 = 8'h01;
        @(negedge clk);
        g0 = '0;
        @(negedge clk);
        `CHK("rst_first", 9'h002, {g0st, irq})
        finish_test();
    end
endmodule
